// ---- lut_cfg_pkg.sv ----
// constants for the logic lookup table and advanced options register bank
package lut_cfg_pkg;

   // ******************************************
   // register offsets
   // ******************************************
   localparam logic [7:0] ADDR_LUT3_BANK_A    = 8'h29;
   localparam logic [7:0] ADDR_LUT4_BANK_B    = 8'h2a;
   localparam logic [7:0] ADDR_LUT4_BANK_A    = 8'h2b;
   localparam logic [7:0] ADDR_ADV_OPTIONS    = 8'had;
   localparam logic [7:0] ADDR_PIN_LEVEL_B    = 8'h10;
   localparam logic [7:0] ADDR_PIN_LEVEL_A    = 8'h11;

   // ******************************************
   // reset values and field layout
   // ******************************************
   localparam logic [7:0] RST_LUT3_BANK_A     = 8'h00;
   localparam logic [7:0] RST_LUT4_BANK_B     = 8'h00;
   localparam logic [7:0] RST_LUT4_BANK_A     = 8'h00;
   localparam logic [7:0] RST_ADV_OPTIONS     = 8'h00;
   localparam int         ADV_AUTOCLR_BIT     = 2;
   localparam int         ADV_BOOST_BIT       = 1;
   localparam logic [7:0] ADV_WRITABLE_MASK   = 8'h06;

   // ******************************************
   // pin positions
   // ******************************************
   localparam int         PIN_SEL_A_LSB       = 0;
   localparam int         PIN_SEL_B_LSB       = 8;
   localparam int         PIN_LUT3_A          = 3;
   localparam int         PIN_LUT4_A          = 4;
   localparam int         PIN_LUT4_B          = 12;
   localparam int         PIN_COUNT           = 16;
   localparam int         SYNC_STAGES         = 2;

   // ******************************************
   // logic mode field encoding
   // ******************************************
   typedef enum logic [1:0]
   {
      MODE_OFF     = 2'h0,
      MODE_3TO1    = 2'h1,
      MODE_3TO2    = 2'h2,
      MODE_SPARE   = 2'h3
   } logic_mode_t;

endpackage : lut_cfg_pkg

// ---- lut3_select.sv ----
// one three-input lookup table: picks table bit n for select code n
`timescale 1ns/1ps
module lut3_select
(
   // table and select
   input  wire logic [7:0] table_bits,
   input  wire logic [2:0] sel,
   // result
   output wire logic       result
);

   assign result = table_bits[sel];

endmodule : lut3_select

// ---- logic_lut_and_irq_autoclear_cfg.sv ----
// lookup table registers, advanced options and lookup-driven pin outputs
// What this block does
// R1 - bank A 3-to-2 mode: pin 3 driven by table 3A bit selected by pins 2..0
// R2 - bank B 3-to-2 mode: pin 12 driven by table 4B bit, pins 10..8; resets zero
// R3 - bank A 3-to-2 mode: pin 4 driven by table 4A bit, pins 2..0; resets zero
// R4 - tables affect pins only while their bank's low mode selects 3-to-2
// R5 - autoclear bit 2 set: reading bank A or B data clears all irq flags
// R6 - autoclear bit 2 clear: data reads leave flags; host clears them itself
// R7 - advanced bit 1 enables drive boost, 0 disables it
// R8 - host writes zeros to advanced bits 7:3 and 0; register resets zero
// R9 - direction 0 makes an output: data 0 drives low (LED on), 1 high
// R10 - lookup outputs follow selects and tables with no extra latency
`timescale 1ns/1ps
module logic_lut_and_irq_autoclear_cfg
(
   // clock and reset
   input  wire logic                               clk,
   input  wire logic                               resetn,
   // register port from the serial bus front end
   input  wire logic [7:0]                         reg_addr,
   input  wire logic [7:0]                         reg_wdata,
   input  wire logic                               reg_wr,
   input  wire logic                               reg_rd,
   output logic      [7:0]                         reg_rdata,
   output wire logic                               reg_hit,
   // mode and pin configuration from the rest of the map
   input  wire lut_cfg_pkg::logic_mode_t           logic_mode_low_bank_a,
   input  wire lut_cfg_pkg::logic_mode_t           logic_mode_low_bank_b,
   input  wire logic [lut_cfg_pkg::PIN_COUNT-1:0]  pin_direction,
   input  wire logic [lut_cfg_pkg::PIN_COUNT-1:0]  pin_level,
   // pins
   input  wire logic [lut_cfg_pkg::PIN_COUNT-1:0]  pin_in,
   output wire logic [lut_cfg_pkg::PIN_COUNT-1:0]  pin_out,
   output wire logic [lut_cfg_pkg::PIN_COUNT-1:0]  pin_oe,
   // controls toward the interrupt and pad logic
   output logic                                    irq_clear,
   output wire logic                               boost_en,
   output wire logic                               irq_autoclear_en
);
   import lut_cfg_pkg::*;

   // ******************************************
   // pin input synchroniser
   // ******************************************
   logic [PIN_COUNT-1:0] pin_sync1_ff;
   logic [PIN_COUNT-1:0] pin_sync2_ff;

   always_ff @(posedge clk)
   begin
      if (!resetn)
      begin
         pin_sync1_ff <= '0;
         pin_sync2_ff <= '0;
      end
      else
      begin
         pin_sync1_ff <= pin_in;
         pin_sync2_ff <= pin_sync1_ff;
      end
   end

   // ******************************************
   // register decode
   // ******************************************
   wire hit_lut3_a = (reg_addr == ADDR_LUT3_BANK_A);
   wire hit_lut4_b = (reg_addr == ADDR_LUT4_BANK_B);
   wire hit_lut4_a = (reg_addr == ADDR_LUT4_BANK_A);
   wire hit_adv    = (reg_addr == ADDR_ADV_OPTIONS);
   wire hit_data   = (reg_addr == ADDR_PIN_LEVEL_A) || (reg_addr == ADDR_PIN_LEVEL_B);

   assign reg_hit = hit_lut3_a | hit_lut4_b | hit_lut4_a | hit_adv;

   // ******************************************
   // registers
   // ******************************************
   logic [7:0] lut3_bank_a_ff;
   logic [7:0] lut4_bank_b_ff;
   logic [7:0] lut4_bank_a_ff;
   logic [7:0] adv_options_ff;
   logic [7:0] nxt_reg_rdata;
   logic       nxt_irq_clear;

   // reserved advanced bits are not stored and read back as zero
   wire [7:0] adv_wdata = reg_wdata & ADV_WRITABLE_MASK; // R8

   always_ff @(posedge clk)
   begin
      if (!resetn)
      begin
         lut3_bank_a_ff <= RST_LUT3_BANK_A;
         lut4_bank_b_ff <= RST_LUT4_BANK_B; // R2
         lut4_bank_a_ff <= RST_LUT4_BANK_A; // R3
         adv_options_ff <= RST_ADV_OPTIONS; // R8
      end
      else if (reg_wr)
      begin
         if (hit_lut3_a)
            lut3_bank_a_ff <= reg_wdata;
         if (hit_lut4_b)
            lut4_bank_b_ff <= reg_wdata;
         if (hit_lut4_a)
            lut4_bank_a_ff <= reg_wdata;
         if (hit_adv)
            adv_options_ff <= adv_wdata;
      end
   end

   always_comb
   begin
      nxt_reg_rdata = 8'h00;
      if (hit_lut3_a)
         nxt_reg_rdata = lut3_bank_a_ff;
      else if (hit_lut4_b)
         nxt_reg_rdata = lut4_bank_b_ff;
      else if (hit_lut4_a)
         nxt_reg_rdata = lut4_bank_a_ff;
      else if (hit_adv)
         nxt_reg_rdata = adv_options_ff;
   end

   // auto-clear fires only on a data read with the option on
   assign irq_autoclear_en = adv_options_ff[ADV_AUTOCLR_BIT];
   assign nxt_irq_clear    = reg_rd && hit_data && irq_autoclear_en; // R5 R6

   always_ff @(posedge clk)
   begin
      if (!resetn)
      begin
         reg_rdata <= 8'h00;
         irq_clear <= 1'b0;
      end
      else
      begin
         reg_rdata <= reg_rd ? nxt_reg_rdata : reg_rdata;
         irq_clear <= nxt_irq_clear;
      end
   end

   assign boost_en = adv_options_ff[ADV_BOOST_BIT]; // R7

   // ******************************************
   // lookup tables and pin drive
   // ******************************************
   wire [2:0] sel_a = pin_sync2_ff[PIN_SEL_A_LSB +: 3];
   wire [2:0] sel_b = pin_sync2_ff[PIN_SEL_B_LSB +: 3];
   wire       lut3_a_out;
   wire       lut4_a_out;
   wire       lut4_b_out;
   wire       mode_a_3to2 = (logic_mode_low_bank_a == MODE_3TO2);
   wire       mode_b_3to2 = (logic_mode_low_bank_b == MODE_3TO2);

   lut3_select u_lut3_a
   (
      .table_bits (lut3_bank_a_ff),
      .sel        (sel_a),
      .result     (lut3_a_out)
   ); // R1 R10

   lut3_select u_lut4_a
   (
      .table_bits (lut4_bank_a_ff),
      .sel        (sel_a),
      .result     (lut4_a_out)
   ); // R3 R10

   lut3_select u_lut4_b
   (
      .table_bits (lut4_bank_b_ff),
      .sel        (sel_b),
      .result     (lut4_b_out)
   ); // R2 R10

   // data bit drives the pin; bank A 3-to-2 mode overrides table pins 3 and 4, bank B 3-to-2 mode overrides pin 12
   logic [PIN_COUNT-1:0] drive_level;

   always_comb
   begin
      drive_level = pin_level; // R9
      if (mode_a_3to2) // R4
      begin
         drive_level[PIN_LUT3_A] = lut3_a_out; // R1
         drive_level[PIN_LUT4_A] = lut4_a_out; // R3
      end
      if (mode_b_3to2) // R4
         drive_level[PIN_LUT4_B] = lut4_b_out; // R2
   end

   assign pin_out = drive_level;
   assign pin_oe  = ~pin_direction; // R9

   // ******************************************
   // assertions
   // ******************************************
   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);

   a_lut3a_pin3: assert property (mode_a_3to2 |-> pin_out[3] == lut3_bank_a_ff[sel_a]) // R1
      else $error("pin 3 does not follow table 3A");
   a_lut4b_pin12: assert property (mode_b_3to2 |-> pin_out[12] == lut4_bank_b_ff[sel_b]) // R2
      else $error("pin 12 does not follow table 4B");
   a_lut4a_pin4: assert property (mode_a_3to2 |-> pin_out[4] == lut4_bank_a_ff[sel_a]) // R3
      else $error("pin 4 does not follow table 4A");
   a_mode_bypass: assert property (!mode_a_3to2 && !mode_b_3to2
      |-> pin_out[4:3] == pin_level[4:3] && pin_out[12] == pin_level[12]) // R4
      else $error("table drives a pin outside 3-to-2 mode");
   a_autoclr_fires: assert property (reg_rd && hit_data && adv_options_ff[2]
      |=> irq_clear ##1 (!irq_clear || $past(reg_rd && hit_data))) // R5
      else $error("data read did not clear interrupt flags");
   a_autoclr_off: assert property (!adv_options_ff[2] |=> !irq_clear) // R6
      else $error("interrupt flags cleared with auto-clear off");
   a_boost_follow: assert property (reg_wr && hit_adv |=> boost_en == $past(reg_wdata[1])) // R7
      else $error("boost enable did not follow the write");
   a_reserved_zero: assert property (reg_rd && hit_adv
      |=> reg_rdata[7:3] == 5'h00 && reg_rdata[0] == 1'b0) // R8
      else $error("reserved advanced bits read nonzero");
   a_lut_reset: assert property ($rose(resetn) |-> lut4_bank_a_ff == 8'h00
      && lut4_bank_b_ff == 8'h00 && adv_options_ff == 8'h00) // R2
      else $error("table or options register not zero after reset");
   a_output_enable: assert property (pin_oe == ~pin_direction) // R9
      else $error("output enable does not track direction");
   a_sync_latency: assert property ((mode_a_3to2 && $stable(lut3_bank_a_ff)) [*3]
      |-> pin_out[3] == lut3_bank_a_ff[$past(pin_in[2:0], 2)]) // R10
      else $error("lookup output latency beyond synchroniser");

   c_mode_a_lut: cover property (mode_a_3to2 && $changed(pin_out[3]));
   c_mode_b_lut: cover property (mode_b_3to2 && $changed(pin_out[12]));
   c_autoclear: cover property (irq_clear);
   c_boost_on: cover property ($rose(boost_en));

endmodule : logic_lut_and_irq_autoclear_cfg

// ---- host_model.sv ----
// host side model driving the register strobe port
`timescale 1ns/1ps
module host_model
   import lut_cfg_pkg::*;
(
   // clock
   input  wire logic       clk,
   // register port
   output logic      [7:0] reg_addr,
   output logic      [7:0] reg_wdata,
   output logic            reg_wr,
   output logic            reg_rd,
   input  wire logic [7:0] reg_rdata
);
   initial
   begin
      reg_addr  = 8'h00;
      reg_wdata = 8'h00;
      reg_wr    = 1'b0;
      reg_rd    = 1'b0;
   end

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      reg_addr  <= a;
      reg_wdata <= (a == ADDR_ADV_OPTIONS) ? (d & ADV_WRITABLE_MASK) : d;
      reg_wr    <= 1'b1;
      @(posedge clk);
      reg_wr    <= 1'b0;
      reg_addr  <= ~a;
      reg_wdata <= ~d;
   endtask : wr

   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge clk);
      reg_rd   <= 1'b0;
      reg_addr <= ~a;
      @(posedge clk);
      #1;
      d = reg_rdata;
   endtask : rd
endmodule : host_model

// ---- tb_logic_lut_and_irq_autoclear_cfg.sv ----
// self-checking bench for the lookup table and advanced options bank
`timescale 1ns/1ps
module tb_logic_lut_and_irq_autoclear_cfg;
   import lut_cfg_pkg::*;
   logic        clk = 1'b0;
   logic        resetn = 1'b0;
   logic [7:0]  reg_addr, reg_wdata, reg_rdata, rd, t3a, t4a, t4b;
   logic        reg_wr, reg_rd, irq_clear, boost_en, irq_autoclear_en, reg_hit;
   logic_mode_t mode_a = MODE_OFF;
   logic_mode_t mode_b = MODE_OFF;
   logic [15:0] pin_direction = 16'h0000;
   logic [15:0] pin_level = 16'h0000;
   logic [15:0] pin_in = 16'h0000;
   logic [15:0] pin_out, pin_oe;
   logic [7:0]  addrs [5] = '{ADDR_LUT3_BANK_A, ADDR_LUT4_BANK_B, ADDR_LUT4_BANK_A,
                             ADDR_ADV_OPTIONS, 8'h55};
   int          fails = 0;
   int          checked = 0;
   int          pulses = 0;
   int          base;

   always #5 clk = ~clk;
   always @(posedge clk) pulses <= pulses + int'(irq_clear === 1'b1);

   // every strobed address must report a hit exactly for the four mapped registers
   wire         exp_hit = reg_addr inside {ADDR_LUT3_BANK_A, ADDR_LUT4_BANK_B,
                                           ADDR_LUT4_BANK_A, ADDR_ADV_OPTIONS};
   always @(posedge clk)
      if (resetn && (reg_rd || reg_wr))
         check("register hit", reg_hit, exp_hit);

   host_model host_model_i (.clk(clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));

   logic_lut_and_irq_autoclear_cfg logic_lut_and_irq_autoclear_cfg_i (.clk(clk),
      .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_hit(reg_hit), .logic_mode_low_bank_a(mode_a),
      .logic_mode_low_bank_b(mode_b), .pin_direction(pin_direction), .pin_level(pin_level),
      .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .irq_clear(irq_clear),
      .boost_en(boost_en), .irq_autoclear_en(irq_autoclear_en));

   task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
      checked++;
      if (seen !== exp)
      begin
         fails++;
         $display("wrong value %s expected %h seen %h", name, exp, seen);
      end
   endtask : check

   task automatic finish_test;
      $display("checked %0d fails %0d", checked, fails);
      if (fails == 0 && checked > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : finish_test

   function automatic logic exp_pin(logic_mode_t m, logic [7:0] t, logic [2:0] c, logic l);
      return (m == MODE_3TO2) ? t[c] : l;
   endfunction : exp_pin

   initial
   begin
      repeat (20000) @(posedge clk);
      fails++;
      finish_test();
   end

   initial
   begin
      void'($urandom(32'h27913828));
      repeat (3) @(posedge clk);
      resetn <= 1'b1;
      foreach (addrs[i])
      begin
         host_model_i.rd(addrs[i], rd);
         check("reset read", rd, 16'h0000);
      end
      check("boost at reset", boost_en, 16'h0000);
      $display("test reset done");
      // every select code under the eight mode pairs where mode_a bit 1 equals mode_b bit 0, random tables
      for (int i = 0; i < 64; i++)
      begin
         t3a = 8'($urandom);
         t4a = 8'($urandom);
         t4b = 8'($urandom);
         host_model_i.wr(ADDR_LUT3_BANK_A, t3a);
         host_model_i.wr(ADDR_LUT4_BANK_A, t4a);
         host_model_i.wr(ADDR_LUT4_BANK_B, t4b);
         host_model_i.rd(ADDR_LUT4_BANK_B, rd);
         check("table 4b", rd, t4b);
         @(posedge clk);
         mode_a <= logic_mode_t'(i[4:3]);
         mode_b <= logic_mode_t'(i[5:4]);
         pin_in <= {5'($urandom), ~i[2:0], 5'($urandom), i[2:0]};
         pin_level <= 16'($urandom);
         pin_direction <= 16'($urandom);
         repeat (3) @(posedge clk);
         #1;
         check("pin 3", pin_out[3], exp_pin(mode_a, t3a, pin_in[2:0], pin_level[3]));
         check("pin 4", pin_out[4], exp_pin(mode_a, t4a, pin_in[2:0], pin_level[4]));
         check("pin 12", pin_out[12], exp_pin(mode_b, t4b, pin_in[10:8], pin_level[12]));
         check("plain pins", pin_out & 16'hefe7, pin_level & 16'hefe7);
         check("enables", pin_oe, ~pin_direction);
      end
      $display("test lookup done");
      for (int i = 0; i < 4; i++)
      begin
         host_model_i.wr(ADDR_ADV_OPTIONS, 8'hf9 | {5'h00, i[1:0], 1'b0});
         host_model_i.rd(ADDR_ADV_OPTIONS, rd);
         check("advanced", rd, {5'h00, i[1:0], 1'b0});
         check("boost", boost_en, i[0]);
         check("autoclear enable", irq_autoclear_en, i[1]);
         base = pulses;
         host_model_i.rd(ADDR_PIN_LEVEL_A, rd);
         host_model_i.rd(ADDR_PIN_LEVEL_B, rd);
         @(posedge clk);
         #1;
         check("clear pulses", 16'(pulses - base), i[1] ? 16'h0002 : 16'h0000);
      end
      $display("test advanced done");
      finish_test();
   end
endmodule : tb_logic_lut_and_irq_autoclear_cfg
